// >>> pmac_mode_check.sv
// Processor mode tracker and privilege / segment access checker.
// Sits between fetch/execute and relative translation; one clock domain.
// Operation
// - Exactly one of absolute, master, slave
// - Absolute and master run every instruction
// - Descriptor base, clock, I/O are privileged
// - Privileged instruction in slave code faults
// - Any fault forces absolute mode
// - Master code may enter absolute mode
// - Inhibit bit 28 ignored in slave mode
// - Absolute addresses and fetches only in absolute
// - Absolute operands may optionally go relative
// - Other modes translate fetches and operands
// - Mode follows fetching segment's type bits
// - Slave entry into master segment at zero
// - Type field: master, slave, data, execute-only
// - Instruction fetch from data segment refused
// - Execute-only segment: fetches only
// - Slave entry into execute-only at zero
// - Execute-only code otherwise acts as slave
// - Write-permit, master-access bits on every segment
// - Clear write-permit refuses every modification
// - Master-access set: master procedures only
// - Access checks apply to slave code only, except the data-segment fetch check, which also covers master
`timescale 1ns/10ps
`include "pmac_cfg.svh"

module pmac_mode_check
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // Instruction issue
  input  wire logic                     insn_valid,
  input  wire logic [`PMAC_INSN_W-1:0]  insn_word,
  input  wire logic                     insn_is_priv,
  input  wire logic                     insn_enter_abs,
  // Memory access request
  input  wire logic                     acc_valid,
  input  wire pmac_pkg::pmac_acc_t      acc_kind,
  input  wire logic [`PMAC_ADDR_W-1:0]  acc_addr,
  input  wire logic                     acc_transfer,
  input  wire logic                     abs_operand_rel,
  input  wire logic [`PMAC_CTL_W-1:0]   seg_ctl,
  // External fault sources
  input  wire logic                     ext_fault,
  // Mode change into relative code
  input  wire logic                     leave_abs,
  input  wire logic [`PMAC_CTL_W-1:0]   new_code_ctl,
  // Mode and address control
  output pmac_pkg::pmac_mode_t          mode,
  output logic                          use_relative,
  output logic                          inhibit_irq,
  // Verdicts
  output logic                          insn_allow,
  output logic                          acc_allow,
  output logic                          fault,
  output pmac_pkg::pmac_fault_t         fault_kind,
  output logic [`PMAC_FAULT_CNT_W-1:0]  fault_count
);

  import pmac_pkg::*;

  typedef struct packed
  {
    pmac_mode_t                    mode;
    logic [1:0]                    code_type;
    logic                          use_rel;
    logic                          inhibit;
    logic                          insn_ok;
    logic                          acc_ok;
    logic                          fault;
    pmac_fault_t                   fkind;
    logic [`PMAC_FAULT_CNT_W-1:0]  fcount;
  } pmac_state_t;

  pmac_state_t state_reg;
  pmac_state_t state_next;
  pmac_fault_t seg_fault;
  logic        priv_bad;
  logic        seg_bad;
  logic        any_fault;
  logic        abs_request;
  logic        operand_rel;
  logic        inhibit_seen;
  logic [1:0]  new_type;

  pmac_seg_check u_seg_check
  (
    .acc_kind     (acc_kind),
    .acc_addr     (acc_addr),
    .acc_transfer (acc_transfer),
    .cur_mode     (state_reg.mode),
    .seg_ctl      (seg_ctl),
    .fault_kind   (seg_fault)
  );

  // Mode from a code segment's type; execute-only behaves as slave
  function automatic pmac_mode_t mode_of(input logic [1:0] t);
    if (t == `PMAC_TYPE_MASTER)
      return PMAC_MODE_MASTER;
    else
      return PMAC_MODE_SLAVE;
  endfunction

  // Request decode, all against the mode held before this edge
  always_comb
  begin
    new_type = new_code_ctl[`PMAC_CTL_TYPE_HI:`PMAC_CTL_TYPE_LO];

    priv_bad = 1'b0;
    if (insn_valid && insn_is_priv)
    begin
      // Descriptor base, clock and I/O work is privileged
      if (state_reg.mode == PMAC_MODE_SLAVE)
      begin
        priv_bad = 1'b1;
      end
    end

    seg_bad = 1'b0;
    if (acc_valid)
    begin
      if (seg_fault != PMAC_FLT_NONE)
      begin
        seg_bad = 1'b1;
      end
    end

    any_fault = 1'b0;
    if (ext_fault || priv_bad || seg_bad)
    begin
      // Any fault source ends relative execution
      any_fault = 1'b1;
    end

    abs_request = 1'b0;
    if (insn_valid && insn_enter_abs)
    begin
      // Only master code may step down into absolute
      if (state_reg.mode == PMAC_MODE_MASTER)
      begin
        abs_request = 1'b1;
      end
    end

    operand_rel = 1'b0;
    if (acc_valid && acc_kind != PMAC_ACC_FETCH)
    begin
      // Fetches never take the relative path in absolute mode
      operand_rel = abs_operand_rel;
    end

    inhibit_seen = 1'b0;
    if (insn_valid)
    begin
      inhibit_seen = insn_word[`PMAC_INHIBIT_BIT];
    end
  end

  always_comb
  begin
    state_next = state_reg;
    // Grants and the fault strobe are one-cycle pulses
    state_next.insn_ok = 1'b0;
    state_next.acc_ok  = 1'b0;
    state_next.fault   = 1'b0;
    state_next.inhibit = 1'b0;

    if (insn_valid && !priv_bad)
    begin
      state_next.insn_ok = 1'b1;
    end
    // Refusal withholds the grant so nothing is written
    if (acc_valid && !seg_bad)
    begin
      state_next.acc_ok = 1'b1;
    end

    if (any_fault)
    begin
      state_next.fault = 1'b1;
    end
    // Counter wraps; software reads differences
    if (any_fault)
    begin
      state_next.fcount = state_reg.fcount + 16'h0001;
    end

    // Kind sticks until the next fault
    if (any_fault)
    begin
      if (priv_bad)
      begin
        state_next.fkind = PMAC_FLT_PRIV;
      end
      else if (seg_bad)
      begin
        state_next.fkind = seg_fault;
      end
      else
      begin
        // External source: no access kind to report
        state_next.fkind = PMAC_FLT_NONE;
      end
    end

    if (leave_abs)
    begin
      // Fault and step-down both drop a pending code change
      if (!any_fault && !abs_request)
      begin
        state_next.code_type = new_type;
      end
    end

    // Single enum register keeps exactly one mode
    case (state_reg.mode)
      PMAC_MODE_ABS:
      begin
        if (any_fault)
        begin
          state_next.mode = PMAC_MODE_ABS;
        end
        else if (leave_abs)
        begin
          state_next.mode = mode_of(new_type);
        end
        else
        begin
          state_next.mode = PMAC_MODE_ABS;
        end
      end
      PMAC_MODE_MASTER:
      begin
        if (any_fault)
        begin
          state_next.mode = PMAC_MODE_ABS;
        end
        else if (abs_request)
        begin
          state_next.mode = PMAC_MODE_ABS;
        end
        else if (leave_abs)
        begin
          state_next.mode = mode_of(new_type);
        end
        else
        begin
          state_next.mode = mode_of(state_reg.code_type);
        end
      end
      PMAC_MODE_SLAVE:
      begin
        if (any_fault)
        begin
          state_next.mode = PMAC_MODE_ABS;
        end
        else if (leave_abs)
        begin
          state_next.mode = mode_of(new_type);
        end
        else
        begin
          state_next.mode = mode_of(state_reg.code_type);
        end
      end
      default:
      begin
        // Unused code falls back to the safe mode
        state_next.mode = PMAC_MODE_ABS;
      end
    endcase

    // Relative path: always outside absolute, opt-in for operands
    case (state_next.mode)
      PMAC_MODE_ABS:
      begin
        state_next.use_rel = operand_rel;
      end
      PMAC_MODE_MASTER:
      begin
        state_next.use_rel = 1'b1;
      end
      PMAC_MODE_SLAVE:
      begin
        state_next.use_rel = 1'b1;
      end
      default:
      begin
        state_next.use_rel = 1'b1;
      end
    endcase

    // Inhibit honoured only in privileged modes
    case (state_reg.mode)
      PMAC_MODE_ABS:
      begin
        state_next.inhibit = inhibit_seen;
      end
      PMAC_MODE_MASTER:
      begin
        state_next.inhibit = inhibit_seen;
      end
      PMAC_MODE_SLAVE:
      begin
        // Slave code cannot hold off interrupts
        state_next.inhibit = 1'b0;
      end
      default:
      begin
        state_next.inhibit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg.mode      <= PMAC_MODE_ABS;
      state_reg.code_type <= `PMAC_RST_CODE_TYPE;
      state_reg.use_rel   <= 1'b0;
      state_reg.inhibit   <= 1'b0;
      state_reg.insn_ok   <= 1'b0;
      state_reg.acc_ok    <= 1'b0;
      state_reg.fault     <= 1'b0;
      state_reg.fkind     <= PMAC_FLT_NONE;
      state_reg.fcount    <= `PMAC_FAULT_CNT_RST;
    end
    else
      state_reg <= state_next;
  end

  assign mode         = state_reg.mode;
  assign use_relative = state_reg.use_rel;
  assign inhibit_irq  = state_reg.inhibit;
  assign insn_allow   = state_reg.insn_ok;
  assign acc_allow    = state_reg.acc_ok;
  assign fault        = state_reg.fault;
  assign fault_kind   = state_reg.fkind;
  assign fault_count  = state_reg.fcount;

endmodule

// >>> pmac_cfg.svh
// Constants for the processor mode and segment access check.
// Included by the package and by the design files; definitions only.
`ifndef PMAC_CFG_SVH
`define PMAC_CFG_SVH

// Segment descriptor control field layout
`define PMAC_CTL_W          6
`define PMAC_CTL_TYPE_LO    0
`define PMAC_CTL_TYPE_HI    1
`define PMAC_CTL_WRITE_BIT  2
`define PMAC_CTL_MASTER_BIT 3
`define PMAC_CTL_PAGED_BIT  4
`define PMAC_CTL_PSIZE_BIT  5

// Segment type codes
`define PMAC_TYPE_MASTER    2'h0
`define PMAC_TYPE_SLAVE     2'h1
`define PMAC_TYPE_DATA      2'h2
`define PMAC_TYPE_EXEC      2'h3

// Instruction word
`define PMAC_INSN_W         36
`define PMAC_INHIBIT_BIT    28

// Address widths
`define PMAC_ADDR_W         18

// Reset values
`define PMAC_RST_CODE_TYPE  2'h0
`define PMAC_FAULT_CNT_W    16
`define PMAC_FAULT_CNT_RST  16'h0000

`endif

// >>> pmac_pkg.sv
// Types shared by the mode and access check files.
// Relies on pmac_cfg.svh for all numeric constants.
`include "pmac_cfg.svh"

package pmac_pkg;

  typedef enum logic [1:0]
  {
    PMAC_MODE_ABS,
    PMAC_MODE_MASTER,
    PMAC_MODE_SLAVE
  } pmac_mode_t;

  typedef enum logic [2:0]
  {
    PMAC_FLT_NONE,
    PMAC_FLT_PRIV,
    PMAC_FLT_FETCH,
    PMAC_FLT_OPERAND,
    PMAC_FLT_WRITE,
    PMAC_FLT_MASTER_ONLY,
    PMAC_FLT_ENTRY
  } pmac_fault_t;

  typedef enum logic [1:0]
  {
    PMAC_ACC_FETCH,
    PMAC_ACC_READ,
    PMAC_ACC_WRITE
  } pmac_acc_t;

endpackage

// >>> pmac_seg_check.sv
// Per-access segment permission check from one descriptor control field.
// Combinational; the caller registers the verdict.
`timescale 1ns/10ps
`include "pmac_cfg.svh"

module pmac_seg_check
  import pmac_pkg::*;
(
  // Access being made
  input  wire pmac_pkg::pmac_acc_t      acc_kind,
  input  wire logic [`PMAC_ADDR_W-1:0]  acc_addr,
  input  wire logic                     acc_transfer,
  // Caller context
  input  wire pmac_pkg::pmac_mode_t     cur_mode,
  input  wire logic [`PMAC_CTL_W-1:0]   seg_ctl,
  // Verdict
  output pmac_pkg::pmac_fault_t         fault_kind
);

  logic [1:0] seg_type;
  logic       checked;

  always_comb
  begin
    seg_type = seg_ctl[`PMAC_CTL_TYPE_HI:`PMAC_CTL_TYPE_LO];
    // Only slave code is fully policed; master fetches are checked against data segments only
    checked = (cur_mode == PMAC_MODE_SLAVE);
    fault_kind = PMAC_FLT_NONE;
    if (checked)
    begin
      // Priority: master-only, write, kind, entry point
      if (seg_ctl[`PMAC_CTL_MASTER_BIT])
        fault_kind = PMAC_FLT_MASTER_ONLY;
      else if (acc_kind == PMAC_ACC_WRITE &&
               !seg_ctl[`PMAC_CTL_WRITE_BIT])
        fault_kind = PMAC_FLT_WRITE;
      else if (acc_kind == PMAC_ACC_FETCH &&
               seg_type == `PMAC_TYPE_DATA)
        fault_kind = PMAC_FLT_FETCH;
      else if (acc_kind != PMAC_ACC_FETCH &&
               seg_type == `PMAC_TYPE_EXEC)
        fault_kind = PMAC_FLT_OPERAND;
      else if (acc_transfer && acc_kind == PMAC_ACC_FETCH &&
               (seg_type == `PMAC_TYPE_MASTER ||
                seg_type == `PMAC_TYPE_EXEC) &&
               acc_addr != '0)
        fault_kind = PMAC_FLT_ENTRY;
    end
    else if (acc_kind == PMAC_ACC_FETCH && cur_mode != PMAC_MODE_ABS &&
             seg_type == `PMAC_TYPE_DATA)
      fault_kind = PMAC_FLT_FETCH;
  end

endmodule

// >>> pmac_mode_monitor.sv
// Checker for the mode and access block, on its ports only.
// Bound to pmac_mode_check from tb_top; one clock domain.
`timescale 1ns/10ps
`include "pmac_cfg.svh"

module pmac_mode_monitor
  import pmac_pkg::*;
(
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  // Requests
  input wire logic                    insn_valid,
  input wire logic [`PMAC_INSN_W-1:0] insn_word,
  input wire logic                    insn_is_priv,
  input wire logic                    acc_valid,
  input wire pmac_pkg::pmac_acc_t     acc_kind,
  input wire logic [`PMAC_CTL_W-1:0]  seg_ctl,
  input wire logic                    ext_fault,
  // Verdicts
  input wire pmac_pkg::pmac_mode_t    mode,
  input wire logic                    use_relative,
  input wire logic                    inhibit_irq,
  input wire logic                    insn_allow,
  input wire logic                    acc_allow,
  input wire logic                    fault,
  input wire pmac_pkg::pmac_fault_t   fault_kind
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_mode_legal: assert property (mode != 2'h3)
    else $error("mode code outside the three modes");
  chk_fault_abs: assert property (fault |-> mode == PMAC_MODE_ABS)
    else $error("fault without absolute mode");
  chk_rel_fetch: assert property (mode != PMAC_MODE_ABS |-> use_relative)
    else $error("relative code without relative addressing");
  chk_priv_slave: assert property (insn_valid && insn_is_priv
    && mode == PMAC_MODE_SLAVE |=> fault && !insn_allow
    && fault_kind == PMAC_FLT_PRIV)
    else $error("privileged slave instruction not refused");
  chk_priv_ok: assert property (insn_valid
    && mode != PMAC_MODE_SLAVE |=> insn_allow)
    else $error("instruction refused outside slave mode");
  chk_inh_slave: assert property (mode == PMAC_MODE_SLAVE
    |=> !inhibit_irq)
    else $error("inhibit honoured in slave mode");
  chk_inh_set: assert property (insn_valid
    && insn_word[`PMAC_INHIBIT_BIT] && mode != PMAC_MODE_SLAVE
    |=> inhibit_irq)
    else $error("inhibit bit not honoured");
  chk_data_fetch: assert property (acc_valid && mode != PMAC_MODE_ABS
    && acc_kind == PMAC_ACC_FETCH && seg_ctl[1:0] == `PMAC_TYPE_DATA
    |=> fault && !acc_allow)
    else $error("fetch from data segment granted");
  chk_write_prot: assert property (acc_valid
    && mode == PMAC_MODE_SLAVE && acc_kind == PMAC_ACC_WRITE
    && !seg_ctl[`PMAC_CTL_WRITE_BIT] |=> fault && !acc_allow)
    else $error("write to protected segment granted");
  chk_master_free: assert property (acc_valid && !ext_fault
    && mode == PMAC_MODE_MASTER && seg_ctl[1:0] != `PMAC_TYPE_DATA
    |=> acc_allow)
    else $error("master access refused");
endmodule

// >>> pmac_fetch_model.sv
// Fetch/execute side model: supplies instruction words.
// Bench seeds $urandom before the first edge.
`timescale 1ns/10ps
`include "pmac_cfg.svh"

module pmac_fetch_model
(
  // Clock and request
  input  wire logic                   sys_clk,
  input  wire logic                   inh,
  // Word to the block
  output logic [`PMAC_INSN_W-1:0]     insn_word
);
  logic [`PMAC_INSN_W-1:0] pat_reg = '0;

  // Bits 35:29 and 27:4 churn and bits 3:0 stay zero, so none can pose as the inhibit bit
  always @(posedge sys_clk)
    pat_reg <= {$urandom, 4'h0};
  assign insn_word = {pat_reg[35:29], inh, pat_reg[27:0]};
endmodule

// >>> tb_top.sv
// Self-checking bench for the mode and access block.
// Expects pmac_pkg, the checker and the fetch model compiled first.
`timescale 1ns/10ps
`include "pmac_cfg.svh"

module tb_top;
  import pmac_pkg::*;
  localparam pmac_acc_t fe = PMAC_ACC_FETCH;
  localparam pmac_acc_t rd = PMAC_ACC_READ;
  localparam pmac_acc_t wr = PMAC_ACC_WRITE;
  logic sys_clk = 0, reset_n = 0, insn_valid = 0, inh = 0;
  logic insn_is_priv = 0, insn_enter_abs = 0, acc_valid = 0;
  logic acc_transfer = 0, abs_operand_rel = 0, ext_fault = 0;
  logic leave_abs = 0, use_relative, inhibit_irq, insn_allow;
  logic acc_allow, fault;
  logic [`PMAC_INSN_W-1:0]      insn_word;
  logic [`PMAC_ADDR_W-1:0]      acc_addr = 0;
  logic [`PMAC_CTL_W-1:0]       seg_ctl = 0, new_code_ctl = 0;
  logic [`PMAC_FAULT_CNT_W-1:0] fault_count, exp_cnt = 0;
  logic [25:0]                  v, vq[$];
  pmac_acc_t                    acc_kind = PMAC_ACC_FETCH;
  pmac_mode_t                   mode, exp_mode = PMAC_MODE_ABS;
  pmac_fault_t                  fault_kind, exp_kind = PMAC_FLT_NONE;
  int                           cyc = 0, dq[$];
  int                           n_mismatch = 0, check_count = 0;

  pmac_mode_check pmac_mode_check_i (.*);
  pmac_fetch_model pmac_fetch_model_i (.*);

  always #2 sys_clk = ~sys_clk;

  task automatic final_report();
    if (vq.size() != 0)
      n_mismatch++;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One instruction and access per cycle; note what must come back
  task automatic step(logic p, ea, av, pmac_acc_t k, logic [17:0] ad,
    logic x, r, logic [5:0] ct, logic ef, lv, logic [5:0] nc, logic ih);
    pmac_fault_t fk;
    logic sl, af, nf;
    pmac_mode_t nm;
    @(posedge sys_clk);
    {insn_valid, insn_is_priv, insn_enter_abs, acc_valid} <= {1'b1, p, ea, av};
    {acc_addr, acc_transfer, abs_operand_rel, seg_ctl} <= {ad, x, r, ct};
    {ext_fault, leave_abs, new_code_ctl, inh} <= {ef, lv, nc, ih};
    acc_kind <= k;
    sl = exp_mode == PMAC_MODE_SLAVE;
    fk = PMAC_FLT_NONE;
    if (!av || exp_mode == PMAC_MODE_ABS) fk = PMAC_FLT_NONE;
    else if (sl && ct[3]) fk = PMAC_FLT_MASTER_ONLY;
    else if (sl && k == wr && !ct[2]) fk = PMAC_FLT_WRITE;
    else if (k == fe && ct[1:0] == 2'h2) fk = PMAC_FLT_FETCH;
    else if (sl && k != fe && ct[1:0] == 2'h3) fk = PMAC_FLT_OPERAND;
    else if (sl && k == fe && x && ad != 0 && ct[1:0] inside {2'h0, 2'h3})
      fk = PMAC_FLT_ENTRY;
    af = fk != PMAC_FLT_NONE;
    if (p && sl) fk = PMAC_FLT_PRIV;
    nf = (p && sl) || af || ef;
    if (nf) exp_kind = fk;
    if (nf) exp_cnt++;
    nm = nf || (ea && exp_mode == PMAC_MODE_MASTER) ? PMAC_MODE_ABS :
      lv ? (nc[1:0] == 2'h0 ? PMAC_MODE_MASTER : PMAC_MODE_SLAVE) : exp_mode;
    vq.push_back({nm, nm != PMAC_MODE_ABS || (exp_mode == PMAC_MODE_ABS
      && av && k != fe && r), ih && !sl, !(p && sl), av && !af, nf,
      exp_kind, exp_cnt});
    dq.push_back(cyc + 2);
    exp_mode = nm;
  endtask

  task automatic sl(pmac_acc_t k, logic [17:0] ad, logic x, logic [5:0] ct);
    step(0, 0, 0, rd, 0, 0, 0, 0, 0, 1, 6'h01, 0);
    step(0, 0, 1, k, ad, x, 0, ct, 0, 0, 0, 0);
  endtask

  // Notes are due after the edge that samples them
  always @(negedge sys_clk)
    if (dq.size() > 0 && cyc >= dq[0])
    begin
      v = vq.pop_front();
      void'(dq.pop_front());
      cmp({mode, use_relative}, v[25:23]);
      cmp({inhibit_irq, insn_allow}, v[22:21]);
      cmp({acc_allow, fault, fault_kind, fault_count}, v[20:0]);
    end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(32'hb609_abb1));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1;
    step(1, 0, 1, rd, 0, 0, 1, 6'h04, 0, 0, 0, 1);
    step(0, 0, 1, fe, 9, 0, 0, 6'h02, 0, 1, 6'h00, 0);
    step(1, 0, 1, wr, 7, 0, 0, 6'h08, 0, 0, 0, 1);
    step(0, 0, 1, fe, 0, 0, 0, 6'h02, 0, 0, 0, 0);
    step(0, 0, 0, rd, 0, 0, 0, 0, 0, 1, 6'h01, 0);
    step(0, 0, 1, rd, 3, 0, 0, 6'h05, 0, 0, 0, 1);
    step(1, 0, 0, rd, 0, 0, 0, 0, 0, 0, 0, 0);
    step(0, 0, 0, rd, 0, 0, 0, 0, 0, 1, 6'h03, 0);
    step(0, 0, 1, wr, 2, 0, 0, 6'h01, 0, 0, 0, 0);
    sl(rd, 0, 0, 6'h0f);
    sl(rd, 4, 0, 6'h07);
    sl(fe, 5, 1, 6'h04);
    sl(fe, 0, 1, 6'h00);
    sl(fe, 0, 1, 6'h07);
    sl(fe, 3, 1, 6'h03);
    sl(fe, 0, 0, 6'h06);
    step(0, 1, 0, rd, 0, 0, 0, 0, 0, 0, 0, 0);
    step(0, 0, 0, rd, 0, 0, 0, 0, 0, 1, 6'h00, 0);
    step(0, 1, 0, rd, 0, 0, 0, 0, 0, 0, 0, 0);
    sl(rd, 1, 0, 6'h05);
    step(0, 0, 0, rd, 0, 0, 0, 0, 1, 0, 0, 0);
    repeat (40)
    begin
      step(0, 0, 0, rd, 0, 0, 0, 0, 0, 1, 6'($urandom), 0);
      step(0, 0, 1, pmac_acc_t'($urandom_range(2)), 18'($urandom),
        1'($urandom), 0, 6'($urandom), 0, 0, 0, 1'($urandom));
    end
    repeat (4) @(posedge sys_clk);
    final_report();
  end
endmodule

bind pmac_mode_check pmac_mode_monitor pmac_mode_monitor_i (.*);
